//--- design/pin_select_defs.svh
/*
 * Offsets, field positions and reset values for the shared-pin function selector.
 * Assumes a 32-bit AHB-Lite register bus with one aligned word per register.
 */
//
// What this block does
// - each pin's function comes from config, direction, amplifier enable and channel select
// - analog, input, amplifier off, own channel selected: analog input that is converted
// - analog, input, amplifier off, other channel selected: analog input, not converted
// - amplifier input pins with amplifier on: amplifier input; own channel selected is prohibited
// - amplifier output pin, amplifier on, channel nine selected: drive output and convert it
// - amplifier output pin, amplifier on, channel nine unselected: drive output, no conversion
// - amplifier enable used for selection is bit seven of the amplifier control register
// - amplifier input pins set digital: digital input or output by direction; no channel select
`ifndef PIN_SELECT_DEFS_SVH
`define PIN_SELECT_DEFS_SVH

// ==========================================================
// register byte offsets
`define OFS_PORT_ANALOG_DIGITAL_CONFIG 8'h00
`define OFS_PORT_DIRECTION_SETTING 8'h04
`define OFS_AMPLIFIER_CONTROL_REGISTER 8'h08
`define OFS_CONVERTER_CHANNEL_SELECT 8'h0c
`define OFS_PIN_FUNCTION_STATUS 8'h10

// ==========================================================
// field positions and widths
`define AMP_ENABLE_BIT 7
`define CHANNEL_W 5
`define CHANNEL_FIRST 5'h08
`define STATUS_ERROR_BIT 9

// ==========================================================
// reset values: pins analog, input, amplifier off, channel 0
`define RST_PORT_CONFIG 3'h7
`define RST_PORT_DIRECTION 3'h7
`define RST_AMP_CONTROL 8'h00
`define RST_CHANNEL 5'h00

`endif

//--- design/pin_select_pkg.sv
/*
 * Types shared by the shared-pin function selector.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package pin_select_pkg;

    // ==========================================================
    // function that a shared pin takes
    typedef enum logic [2:0] {
        FN_ANALOG_CONV,
        FN_ANALOG_IDLE,
        FN_AMP_IN,
        FN_AMP_OUT_CONV,
        FN_AMP_OUT,
        FN_DIG_IN,
        FN_DIG_OUT,
        FN_PROHIBITED
    } pin_func_t;

endpackage : pin_select_pkg

//--- design/pin_function_decode.sv
/*
 * Combinational decode of one shared pin's function.
 * Assumes all four settings are stable register values of the same clock domain.
 */
`timescale 1ns/1ps
module pin_function_decode import pin_select_pkg::*; #(
    parameter bit AMP_OUTPUT_PIN = 1'b0 // pin carries the amplifier output
) (
    input wire logic analog_i,    // pin configured analog
    input wire logic input_dir_i, // direction is input
    input wire logic amp_en_i,    // amplifier enable bit
    input wire logic chan_hit_i,  // converter selects this pin's channel
    output pin_func_t func_o      // resulting pin function
);

    // ==========================================================
    // joint decode of the four settings
    always_comb begin
        func_o = FN_PROHIBITED;
        if (analog_i) begin
            if (!input_dir_i) begin
                func_o = FN_PROHIBITED;
            end else if (!amp_en_i) begin
                func_o = chan_hit_i ? FN_ANALOG_CONV : FN_ANALOG_IDLE;
            end else if (AMP_OUTPUT_PIN) begin
                func_o = chan_hit_i ? FN_AMP_OUT_CONV : FN_AMP_OUT;
            end else begin
                func_o = chan_hit_i ? FN_PROHIBITED : FN_AMP_IN;
            end
        end else begin
            // the output pin loses digital use while the amplifier runs
            if (chan_hit_i || (AMP_OUTPUT_PIN && amp_en_i)) begin
                func_o = FN_PROHIBITED;
            end else begin
                func_o = input_dir_i ? FN_DIG_IN : FN_DIG_OUT;
            end
        end
    end

endmodule : pin_function_decode

//--- design/analog_amp_pin_function_select.sv
/*
 * Function selector for three shared pins: converter input, amplifier input or output,
 * digital input or output, with an AHB-Lite register slave.
 * Assumes one clock, an AHB-Lite master with single word transfers, this slave alone on hready.
 */
`timescale 1ns/1ps
`include "pin_select_defs.svh"
module analog_amp_pin_function_select import pin_select_pkg::*; #(
    parameter int PINS = 3 // shared pins a, b, c
) (
    input wire logic clock_i,                      // system clock, 125 MHz
    input wire logic sys_rst_i,                    // async reset, active high
    input wire logic hsel_i,                       // slave select
    input wire logic [31:0] haddr_i,               // byte address
    input wire logic [1:0] htrans_i,               // transfer type
    input wire logic hwrite_i,                     // write when high
    input wire logic [2:0] hsize_i,                // transfer size, word only
    input wire logic [31:0] hwdata_i,              // write data
    input wire logic hready_i,                     // bus ready
    output logic [31:0] hrdata_o,                  // read data
    output logic hreadyout_o,                      // slave ready
    output logic hresp_o,                          // always okay
    output logic [3*PINS-1:0] pin_func_o,          // 3-bit function per pin
    output logic [PINS-1:0] convert_route_o,       // pin routed to the converter
    output logic [PINS-1:0] dig_out_en_o,          // digital output driver on
    output logic [PINS-1:0] dig_in_en_o,           // digital input buffer on
    output logic [PINS-1:0] amp_connect_o,         // pin tied to the amplifier
    output logic amp_enable_o,                     // amplifier powered
    output logic [`CHANNEL_W-1:0] conv_channel_o,  // converter channel in use
    output logic setting_error_o                   // prohibited combination present
);

    // ==========================================================
    // register state
    logic [PINS-1:0] port_analog_digital_config;
    logic [PINS-1:0] port_direction_setting;
    logic [7:0] amplifier_control_register;
    logic [`CHANNEL_W-1:0] converter_channel_select;
    logic [PINS-1:0] next_config;
    logic [PINS-1:0] next_direction;
    logic [7:0] next_amp_control;
    logic [`CHANNEL_W-1:0] next_channel;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic next_wr_pend;
    logic [7:0] next_wr_addr;
    logic [31:0] next_hrdata;
    logic amplifier_enable_bit;
    logic bus_take;

    pin_func_t dec_func [PINS];
    logic [3*PINS-1:0] next_pin_func;
    logic [PINS-1:0] next_convert;
    logic [PINS-1:0] next_dig_out;
    logic [PINS-1:0] next_dig_in;
    logic [PINS-1:0] next_amp_connect;
    logic next_error;

    // converter channel that belongs to pin k
    function automatic logic chan_hit(input logic [`CHANNEL_W-1:0] sel, input int k);
        return sel == (`CHANNEL_FIRST + `CHANNEL_W'(k));
    endfunction : chan_hit

    assign amplifier_enable_bit = amplifier_control_register[`AMP_ENABLE_BIT];
    assign bus_take = hsel_i && htrans_i[1] && hready_i;

    // ==========================================================
    // bus slave: writes land in the data phase; register reads look at next values, status reads the registered outputs
    // so a read right behind a write to the same word sees the new data
    always_comb begin
        next_config = port_analog_digital_config;
        next_direction = port_direction_setting;
        next_amp_control = amplifier_control_register;
        next_channel = converter_channel_select;
        if (wr_pend) begin
            unique case (wr_addr)
                `OFS_PORT_ANALOG_DIGITAL_CONFIG: next_config = hwdata_i[PINS-1:0];
                `OFS_PORT_DIRECTION_SETTING: next_direction = hwdata_i[PINS-1:0];
                `OFS_AMPLIFIER_CONTROL_REGISTER: next_amp_control = hwdata_i[7:0];
                `OFS_CONVERTER_CHANNEL_SELECT: next_channel = hwdata_i[`CHANNEL_W-1:0];
                default: next_config = port_analog_digital_config; // unmapped or read-only
            endcase
        end
        next_wr_pend = bus_take && hwrite_i;
        next_wr_addr = haddr_i[7:0];
        next_hrdata = hrdata_o;
        if (bus_take && !hwrite_i) begin
            next_hrdata = 32'h0000_0000;
            unique case (haddr_i[7:0])
                `OFS_PORT_ANALOG_DIGITAL_CONFIG: next_hrdata[PINS-1:0] = next_config;
                `OFS_PORT_DIRECTION_SETTING: next_hrdata[PINS-1:0] = next_direction;
                `OFS_AMPLIFIER_CONTROL_REGISTER: next_hrdata[7:0] = next_amp_control;
                `OFS_CONVERTER_CHANNEL_SELECT: next_hrdata[`CHANNEL_W-1:0] = next_channel;
                `OFS_PIN_FUNCTION_STATUS: next_hrdata[`STATUS_ERROR_BIT:0] = {setting_error_o, pin_func_o};
                default: next_hrdata = 32'h0000_0000; // unmapped reads zero
            endcase
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            port_analog_digital_config <= `RST_PORT_CONFIG;
            port_direction_setting <= `RST_PORT_DIRECTION;
            amplifier_control_register <= `RST_AMP_CONTROL;
            converter_channel_select <= `RST_CHANNEL;
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            hrdata_o <= 32'h0000_0000;
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end else begin
            port_analog_digital_config <= next_config;
            port_direction_setting <= next_direction;
            amplifier_control_register <= next_amp_control;
            converter_channel_select <= next_channel;
            wr_pend <= next_wr_pend;
            wr_addr <= next_wr_addr;
            hrdata_o <= next_hrdata;
            hreadyout_o <= 1'b1; // no wait states
            hresp_o <= 1'b0;
        end
    end

    // ==========================================================
    // one decoder per shared pin; the middle pin carries the amplifier output
    for (genvar k = 0; k < PINS; k++) begin : g_pin
        pin_function_decode #(
            .AMP_OUTPUT_PIN(k == 1)
        ) u_decode (
            .analog_i(port_analog_digital_config[k]),
            .input_dir_i(port_direction_setting[k]),
            .amp_en_i(amplifier_enable_bit),
            .chan_hit_i(chan_hit(converter_channel_select, k)),
            .func_o(dec_func[k])
        );
    end

    // ==========================================================
    // pin controls: a prohibited combination turns every driver off for that pin
    always_comb begin
        next_error = 1'b0;
        for (int k = 0; k < PINS; k++) begin
            next_pin_func[3*k +: 3] = dec_func[k];
            next_convert[k] = (dec_func[k] == FN_ANALOG_CONV) || (dec_func[k] == FN_AMP_OUT_CONV);
            next_dig_out[k] = dec_func[k] == FN_DIG_OUT;
            next_dig_in[k] = dec_func[k] == FN_DIG_IN;
            next_amp_connect[k] = (dec_func[k] == FN_AMP_IN) || (dec_func[k] == FN_AMP_OUT)
                || (dec_func[k] == FN_AMP_OUT_CONV);
            next_error = next_error || (dec_func[k] == FN_PROHIBITED);
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pin_func_o <= '0;
            convert_route_o <= '0;
            dig_out_en_o <= '0;
            dig_in_en_o <= '0;
            amp_connect_o <= '0;
            amp_enable_o <= 1'b0;
            conv_channel_o <= `RST_CHANNEL;
            setting_error_o <= 1'b0;
        end else begin
            pin_func_o <= next_pin_func;
            convert_route_o <= next_convert;
            dig_out_en_o <= next_dig_out;
            dig_in_en_o <= next_dig_in;
            amp_connect_o <= next_amp_connect;
            amp_enable_o <= amplifier_enable_bit;
            conv_channel_o <= converter_channel_select;
            setting_error_o <= next_error;
        end
    end

    // ==========================================================
    // checks: outputs follow the settings one edge later
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_amp_write;
        bus_take && hwrite_i && haddr_i[7:0] == `OFS_AMPLIFIER_CONTROL_REGISTER
            ##1 hready_i;
    endsequence

    property p_analog_conv;
        port_analog_digital_config[0] && port_direction_setting[0] && !amplifier_enable_bit
            && converter_channel_select == 5'h08
            |=> pin_func_o[2:0] == FN_ANALOG_CONV && convert_route_o[0] && !dig_out_en_o[0];
    endproperty
    a_analog_conv: assert property (p_analog_conv) else $error("converted analog input missing");

    property p_analog_idle;
        port_analog_digital_config[2] && port_direction_setting[2] && !amplifier_enable_bit
            && converter_channel_select != 5'h0a
            |=> pin_func_o[8:6] == FN_ANALOG_IDLE && !convert_route_o[2];
    endproperty
    a_analog_idle: assert property (p_analog_idle) else $error("unconverted analog input wrong");

    property p_amp_in;
        port_analog_digital_config[2] && port_direction_setting[2] && amplifier_enable_bit
            && converter_channel_select != 5'h0a
            |=> amp_connect_o[2] && pin_func_o[8:6] == FN_AMP_IN && !convert_route_o[2];
    endproperty
    a_amp_in: assert property (p_amp_in) else $error("amplifier input not connected");

    property p_amp_in_conflict;
        port_analog_digital_config[0] && port_direction_setting[0] && amplifier_enable_bit
            && converter_channel_select == 5'h08
            |=> setting_error_o && !amp_connect_o[0] && !convert_route_o[0];
    endproperty
    a_amp_in_conflict: assert property (p_amp_in_conflict) else $error("amplifier input conflict missed");

    property p_amp_out_conv;
        port_analog_digital_config[1] && port_direction_setting[1] && amplifier_enable_bit
            && converter_channel_select == 5'h09
            |=> amp_connect_o[1] && convert_route_o[1] && pin_func_o[5:3] == FN_AMP_OUT_CONV;
    endproperty
    a_amp_out_conv: assert property (p_amp_out_conv) else $error("amplifier output not converted");

    property p_amp_out;
        port_analog_digital_config[1] && port_direction_setting[1] && amplifier_enable_bit
            && converter_channel_select != 5'h09
            |=> amp_connect_o[1] && !convert_route_o[1];
    endproperty
    a_amp_out: assert property (p_amp_out) else $error("amplifier output drive wrong");

    property p_enable_write;
        // register lands at the data edge, the output copy one edge after that
        s_amp_write |=> ##1 amp_enable_o == $past(hwdata_i[`AMP_ENABLE_BIT], 2);
    endproperty
    a_enable_write: assert property (p_enable_write) else $error("amplifier enable not taken from bit 7");

    property p_digital;
        !port_analog_digital_config[0] && converter_channel_select != 5'h08
            |=> dig_out_en_o[0] == !$past(port_direction_setting[0]) && dig_in_en_o[0] == $past(port_direction_setting[0]);
    endproperty
    a_digital: assert property (p_digital) else $error("digital pin direction wrong");

    property p_digital_select;
        !port_analog_digital_config[2] && converter_channel_select == 5'h0a
            |=> setting_error_o && !dig_out_en_o[2] && !dig_in_en_o[2];
    endproperty
    a_digital_select: assert property (p_digital_select) else $error("digital pin conflict missed");

endmodule : analog_amp_pin_function_select

//--- test/analog_amp_pin_function_select_tb.sv
/*
 * Self-checking bench for the shared-pin function selector: register reset values,
 * status and unmapped accesses, and every setting combination for all three pins.
 * Assumes the design's AHB-Lite slave is alone on the bus, so hreadyout drives hready.
 */
`timescale 1ns/1ps
`include "pin_select_defs.svh"
module analog_amp_pin_function_select_tb;
    // ==========================================================
    // clock, reset and bus signals
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    wire logic hready;
    wire logic [31:0] hrdata;
    wire logic hresp;
    wire logic [8:0] pin_func;
    wire logic [2:0] conv_route, dig_out_en, dig_in_en, amp_connect;
    wire logic amp_en;
    wire logic [4:0] conv_channel;
    wire logic set_err;
    int err_total = 0;
    int n_tests = 0;

    // half period of 4 ns gives 125 MHz
    always #4 clk = ~clk;

    analog_amp_pin_function_select #(.PINS(3)) dut (
        .clock_i(clk), .sys_rst_i(sys_rst), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready),
        .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .pin_func_o(pin_func),
        .convert_route_o(conv_route), .dig_out_en_o(dig_out_en), .dig_in_en_o(dig_in_en),
        .amp_connect_o(amp_connect), .amp_enable_o(amp_en), .conv_channel_o(conv_channel),
        .setting_error_o(set_err)
    );

    // ==========================================================
    // verdict and comparison
    task results;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : results

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", name, exp, got);
            err_total++;
        end
    endtask : chk

    // waits for hready high, bounded so a stuck slave ends the run
    task automatic wait_ready;
        int k;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (hready !== 1'b1 && k < 50);
        if (hready !== 1'b1) begin
            err_total++;
            results();
        end
    endtask : wait_ready

    // one single word transfer; entered and left just after a rising edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        hsize <= 3'h2;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask : bus

    // expected function code of pin p; pin 1 carries the amplifier output
    function automatic logic [2:0] exp_code(input int p, input logic an, dr, amp, hit);
        if (an && !dr) return 3'h7;
        if (an) begin
            if (!amp) return hit ? 3'h0 : 3'h1;
            if (p == 1) return hit ? 3'h3 : 3'h4;
            return hit ? 3'h7 : 3'h2;
        end
        if (hit || (p == 1 && amp)) return 3'h7;
        return dr ? 3'h5 : 3'h6;
    endfunction : exp_code

    // ==========================================================
    // main sequence
    initial begin
        logic [31:0] rd;
        logic [2:0] cfg, dir, c, e_conv, e_dout, e_din, e_amp;
        logic [8:0] e_func;
        logic amp, e_err;
        logic [4:0] ch;
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        // reset values, then status write ignored and unmapped address reads zero
        bus(1'b0, `OFS_PORT_ANALOG_DIGITAL_CONFIG, 32'h0, rd);
        chk("config reset", 32'h7, rd);
        bus(1'b0, `OFS_PORT_DIRECTION_SETTING, 32'h0, rd);
        chk("direction reset", 32'h7, rd);
        bus(1'b0, `OFS_AMPLIFIER_CONTROL_REGISTER, 32'h0, rd);
        chk("amp control reset", 32'h0, rd);
        bus(1'b0, `OFS_CONVERTER_CHANNEL_SELECT, 32'h0, rd);
        chk("channel reset", 32'h0, rd);
        bus(1'b1, `OFS_PIN_FUNCTION_STATUS, 32'hffffffff, rd);
        bus(1'b0, `OFS_PIN_FUNCTION_STATUS, 32'h0, rd);
        chk("status reset", 32'h49, rd);
        bus(1'b0, 8'h14, 32'h0, rd);
        chk("unmapped read", 32'h0, rd);
        $display("test reset values done");
        // every combination of config, direction, amplifier bit and channel, pins differing
        for (int i = 0; i < 32; i++) begin
            cfg = {i[0], ~i[0], i[0]};
            dir = {~i[1], i[1], i[1]};
            amp = i[2];
            ch = (i[4:3] == 2'd0) ? 5'h00 : `CHANNEL_FIRST + 5'(i[4:3]) - 5'h01;
            bus(1'b1, `OFS_PORT_ANALOG_DIGITAL_CONFIG, {29'h0, cfg}, rd);
            bus(1'b1, `OFS_PORT_DIRECTION_SETTING, {29'h0, dir}, rd);
            // low control bits set too: only bit seven may enable the amplifier
            bus(1'b1, `OFS_AMPLIFIER_CONTROL_REGISTER, {24'h0, amp, 7'h55}, rd);
            bus(1'b1, `OFS_CONVERTER_CHANNEL_SELECT, {27'h0, ch}, rd);
            // outputs follow one edge after the last data edge; two spare
            repeat (3) @(posedge clk);
            e_err = 1'b0;
            for (int p = 0; p < 3; p++) begin
                c = exp_code(p, cfg[p], dir[p], amp, ch == `CHANNEL_FIRST + 5'(p));
                e_func[3*p +: 3] = c;
                e_conv[p] = (c == 3'h0 || c == 3'h3);
                e_dout[p] = (c == 3'h6);
                e_din[p] = (c == 3'h5);
                e_amp[p] = (c == 3'h2 || c == 3'h3 || c == 3'h4);
                e_err = e_err | (c == 3'h7);
            end
            chk("pin_func", {23'h0, e_func}, {23'h0, pin_func});
            chk("convert_route", {29'h0, e_conv}, {29'h0, conv_route});
            chk("dig_out_en", {29'h0, e_dout}, {29'h0, dig_out_en});
            chk("dig_in_en", {29'h0, e_din}, {29'h0, dig_in_en});
            chk("amp_connect", {29'h0, e_amp}, {29'h0, amp_connect});
            chk("amp_enable", {31'h0, amp}, {31'h0, amp_en});
            chk("conv_channel", {27'h0, ch}, {27'h0, conv_channel});
            // combinations that software must avoid are driven on purpose and must raise the error
            chk("setting_error", {31'h0, e_err}, {31'h0, set_err});
            bus(1'b0, `OFS_AMPLIFIER_CONTROL_REGISTER, 32'h0, rd);
            chk("amp control readback", {24'h0, amp, 7'h55}, rd);
            bus(1'b0, `OFS_PIN_FUNCTION_STATUS, 32'h0, rd);
            chk("status", {22'h0, e_err, e_func}, rd);
        end
        $display("test setting combinations done");
        results();
    end
endmodule : analog_amp_pin_function_select_tb
